// [design/pmbcs_pkg.sv]
// Package: constants, register map and carrier types of the power bus command handler.
// Assumes a 50 MHz core clock. Voltages of the output use a 2^-12 V mantissa.
// Every other quantity is a plain integer in its own unit.
package pmbcs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ         = 50_000;
  localparam int STORE_MS        = 500;
  localparam int RESTORE_MS      = 200;
  localparam int STORE_CYC_DEF   = STORE_MS * CLK_KHZ;
  localparam int RESTORE_CYC_DEF = RESTORE_MS * CLK_KHZ;
  localparam int BUSY_W          = 25;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR   = 8'h03;
  localparam logic [7:0] CMD_STORE   = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12;
  localparam logic [7:0] CMD_FORMAT  = 8'h20;
  localparam logic [7:0] CMD_SET     = 8'h21;
  localparam logic [7:0] CMD_TRIM    = 8'h23;
  localparam logic [7:0] CMD_MHI     = 8'h25;
  localparam logic [7:0] CMD_MLO     = 8'h26;
  localparam logic [7:0] CMD_DROOP   = 8'h28;
  localparam logic [7:0] CMD_VON     = 8'h35;
  localparam logic [7:0] CMD_VOFF    = 8'h36;
  localparam logic [7:0] CMD_OVL     = 8'h40;
  localparam logic [7:0] CMD_OVA     = 8'h41;
  localparam logic [7:0] CMD_OCL     = 8'h46;
  localparam logic [7:0] CMD_OCA     = 8'h47;
  localparam logic [7:0] CMD_OCW     = 8'h4a;
  localparam logic [7:0] CMD_OTL     = 8'h4f;
  localparam logic [7:0] CMD_OTA     = 8'h50;
  localparam logic [7:0] CMD_OTW     = 8'h51;
  localparam logic [7:0] CMD_VINOV   = 8'h55;

  // ----------------------------------------------------------------------
  // Limits (least values round up, greatest round down)
  // ----------------------------------------------------------------------
  localparam int VSCALE = 4096;
  localparam logic [15:0] VSET_MIN   = 16'((9600 * VSCALE + 999) / 1000);
  localparam logic [15:0] VSET_MAX   = 16'((13200 * VSCALE) / 1000);
  localparam logic [15:0] TRIM_LIM   = 16'((250 * VSCALE) / 1000);
  localparam logic [15:0] OV_MIN     = 16'((10900 * VSCALE + 999) / 1000);
  localparam logic [15:0] OV_MAX     = 16'((15990 * VSCALE) / 1000);
  localparam logic [15:0] OV_HEAD    = 16'((3000 * VSCALE) / 1000);
  localparam logic [15:0] DROOP_MAX  = 16'h0032;
  localparam logic [15:0] VON_MIN    = 16'h0022;
  localparam logic [15:0] VIN_MAX    = 16'h002e;
  localparam logic [15:0] VOFF_MIN   = 16'h0020;
  localparam logic [15:0] VIN_HYST   = 16'h0002;
  localparam logic [15:0] OCL_MIN    = 16'h0014;
  localparam logic [15:0] OCW_MIN    = 16'h000a;
  localparam logic [15:0] OC_MAX     = 16'h003c;
  localparam logic [15:0] OT_MIN     = 16'h0019;
  localparam logic [15:0] OTL_MAX    = 16'h008c;
  localparam logic [15:0] OTW_MAX    = 16'h007d;
  localparam logic [15:0] VINOV_MIN  = 16'h0030;
  localparam logic [15:0] VINOV_MAX  = 16'h005a;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FORMAT_VAL   = 8'h14;
  localparam logic [15:0] SET_STD      = 16'hc000;
  localparam logic [15:0] SET_ALT      = 16'hc333;
  localparam logic [15:0] DROOP_STD    = 16'h0000;
  localparam logic [15:0] DROOP_PAR    = 16'h000a;
  localparam logic [15:0] TRIM_DEF     = 16'h0000;
  localparam logic [15:0] MHI_DEF      = 16'hc99a;
  localparam logic [15:0] MLO_DEF      = 16'hb666;
  localparam logic [15:0] VON_DEF      = 16'h0022;
  localparam logic [15:0] VOFF_DEF     = 16'h0020;
  localparam logic [15:0] OVL_DEF      = 16'he000;
  localparam logic [15:0] OCL_DEF      = 16'h0037;
  localparam logic [15:0] OCW_DEF      = 16'h0032;
  localparam logic [15:0] OTL_DEF      = 16'h007d;
  localparam logic [15:0] OTW_DEF      = 16'h006e;
  localparam logic [15:0] VINOV_DEF    = 16'h0050;
  localparam logic [7:0]  OVA_RST      = 8'hb8;
  localparam logic [7:0]  OCA_RST      = 8'hf8;
  localparam logic [7:0]  OTA_RST      = 8'h80;
  localparam logic [7:0]  ACT_RW_MASK  = 8'h38;
  localparam int          RS_LSB       = 3;
  localparam logic [2:0]  RS_OFF       = 3'h0;
  localparam logic [2:0]  RS_CONT      = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    R_SET = 4'h0, R_TRIM = 4'h1, R_MHI = 4'h2, R_MLO = 4'h3,
    R_DROOP = 4'h4, R_VON = 4'h5, R_VOFF = 4'h6, R_OVL = 4'h7,
    R_OVA = 4'h8, R_OCL = 4'h9, R_OCA = 4'ha, R_OCW = 4'hb,
    R_OTL = 4'hc, R_OTA = 4'hd, R_OTW = 4'he, R_VINOV = 4'hf
  } pmbcs_reg_e;

  typedef logic [15:0][15:0] pmbcs_regs_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [15:0] data;
  } pmbcs_req_s;

  typedef struct packed {
    logic vin_ov;
    logic ot_warn;
    logic ot;
    logic oc_warn;
    logic oc;
    logic ov;
  } pmbcs_fault_s;

  typedef struct packed {
    pmbcs_fault_s lat;
    logic         cml_cmd;
    logic         cml_data;
  } pmbcs_status_s;

endpackage

// [design/pmbcs_top.sv]
// Command handler of a power module management port: parameter store, limits, fault actions.
// Assumes a bus front end on the link clock that hands over one decoded command at a time,
// and fault comparators whose levels arrive asynchronously.
// Operation
// - Save-all copies parameters, busy up to 500 ms
// - Reload-all restores parameters, busy up to 200 ms
// - Output format byte reads fixed 0x14
// - Setpoint is 16-bit mantissa, default 0xC000/0xC333
// - Setpoint accepted only 9.6 V to 13.2 V
// - Trim offset read/write within plus/minus 0.25 V
// - Margins in range, high above low
// - Droop 0 to 50, default 0 or 10
// - Input on/off thresholds keep 2 V hysteresis
// - Overvoltage limit in range, above setpoint
// - Effective overvoltage capped at setpoint plus 3 V
// - Overvoltage action fixed 10, retry bits writable
// - Overcurrent action fixed 11, retry bits writable
// - Overtemperature action fixed 10, retry bits writable
// - Retry 000 stays off, 111 restarts
// - Shutdown delay field zero, no delay
// - Overcurrent fault above warning, both in range
// - Overtemperature fault above warning, both in range
// - Input overvoltage limit 48 V to 90 V
module pmbcs_top
  import pmbcs_pkg::*;
#(
  parameter bit ALT_SETPOINT    = 1'b0,
  parameter bit PARALLEL_BUILD  = 1'b0,
  parameter int STORE_CYCLES    = STORE_CYC_DEF,
  parameter int RESTORE_CYCLES  = RESTORE_CYC_DEF
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          link_clk_in,
  input  wire logic          lnk_req_valid_in,
  input  wire pmbcs_req_s    lnk_req_in,
  output logic               lnk_ready_out,
  output logic               lnk_rsp_valid_out,
  output logic [15:0]        lnk_rsp_data_out,
  input  wire pmbcs_fault_s  fault_in,
  output logic               unit_enable_out,
  output logic [15:0]        ov_limit_eff_out,
  output pmbcs_status_s      status_out,
  output logic               nvm_busy_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic act_ok(input logic [15:0] v, input logic [7:0] rst);
    logic [2:0] rs;
    rs = v[RS_LSB +: 3];
    return (v[15:8] == 8'h00) && ((v[7:0] & ~ACT_RW_MASK) == (rst & ~ACT_RW_MASK))
           && ((rs == RS_OFF) || (rs == RS_CONT));
  endfunction

  // Whole-map check, so a write is judged against every neighbour it affects
  function automatic logic regs_ok(input pmbcs_regs_t r);
    logic trim_ok;
    trim_ok = ($signed(r[R_TRIM]) <= $signed(TRIM_LIM)) &&
              ($signed(r[R_TRIM]) >= -$signed(TRIM_LIM));
    return in_rng(r[R_SET], VSET_MIN, VSET_MAX) && trim_ok
        && in_rng(r[R_MHI], VSET_MIN, VSET_MAX) && in_rng(r[R_MLO], VSET_MIN, VSET_MAX)
        && (r[R_MHI] > r[R_MLO])
        && (r[R_DROOP] <= DROOP_MAX)
        && in_rng(r[R_VON], VON_MIN, VIN_MAX) && in_rng(r[R_VOFF], VOFF_MIN, VIN_MAX)
        && ({1'b0, r[R_VON]} >= ({1'b0, r[R_VOFF]} + {1'b0, VIN_HYST}))
        && in_rng(r[R_OVL], OV_MIN, OV_MAX) && (r[R_OVL] > r[R_SET])
        && act_ok(r[R_OVA], OVA_RST) && act_ok(r[R_OCA], OCA_RST)
        && act_ok(r[R_OTA], OTA_RST)
        && in_rng(r[R_OCL], OCL_MIN, OC_MAX) && in_rng(r[R_OCW], OCW_MIN, OC_MAX)
        && (r[R_OCL] > r[R_OCW])
        && in_rng(r[R_OTL], OT_MIN, OTL_MAX) && in_rng(r[R_OTW], OT_MIN, OTW_MAX)
        && (r[R_OTL] > r[R_OTW])
        && in_rng(r[R_VINOV], VINOV_MIN, VINOV_MAX);
  endfunction

  function automatic logic [15:0] ov_cap(input pmbcs_regs_t r);
    logic [16:0] head;
    logic [15:0] cap;
    head = {1'b0, r[R_SET]} + {1'b0, OV_HEAD};
    cap  = (head > {1'b0, OV_MAX}) ? OV_MAX : head[15:0];
    return (r[R_OVL] < cap) ? r[R_OVL] : cap;
  endfunction

  function automatic logic [4:0] cmd_to_reg(input logic [7:0] code);
    unique case (code)
      CMD_SET:   return {1'b1, R_SET};
      CMD_TRIM:  return {1'b1, R_TRIM};
      CMD_MHI:   return {1'b1, R_MHI};
      CMD_MLO:   return {1'b1, R_MLO};
      CMD_DROOP: return {1'b1, R_DROOP};
      CMD_VON:   return {1'b1, R_VON};
      CMD_VOFF:  return {1'b1, R_VOFF};
      CMD_OVL:   return {1'b1, R_OVL};
      CMD_OVA:   return {1'b1, R_OVA};
      CMD_OCL:   return {1'b1, R_OCL};
      CMD_OCA:   return {1'b1, R_OCA};
      CMD_OCW:   return {1'b1, R_OCW};
      CMD_OTL:   return {1'b1, R_OTL};
      CMD_OTA:   return {1'b1, R_OTA};
      CMD_OTW:   return {1'b1, R_OTW};
      CMD_VINOV: return {1'b1, R_VINOV};
      default:   return 5'h00;
    endcase
  endfunction

  localparam pmbcs_regs_t REG_RESET = {
    VINOV_DEF, OTW_DEF, {8'h00, OTA_RST}, OTL_DEF, OCW_DEF, {8'h00, OCA_RST}, OCL_DEF,
    {8'h00, OVA_RST}, OVL_DEF, VOFF_DEF, VON_DEF,
    (PARALLEL_BUILD ? DROOP_PAR : DROOP_STD), MLO_DEF, MHI_DEF, TRIM_DEF,
    (ALT_SETPOINT ? SET_ALT : SET_STD)};

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pmbcs_regs_t   regs;
    pmbcs_regs_t   nvm;
    logic          req_s1;
    logic          req_s2;
    logic          req_seen;
    pmbcs_fault_s  f_s1;
    pmbcs_fault_s  f_s2;
    pmbcs_status_s stat;
    logic [2:0]    off;
    logic          unit_en;
    logic [15:0]   ov_eff;
    logic          busy;
    logic          op_store;
    logic [BUSY_W-1:0] busy_cnt;
    logic          ack_tgl;
    logic [15:0]   rsp;
  } pmbcs_core_s;

  typedef struct packed {
    pmbcs_req_s    req;
    logic          req_tgl;
    logic          ready;
    logic          ack_s1;
    logic          ack_s2;
    logic          ack_seen;
    logic          rsp_valid;
    logic [15:0]   rsp_data;
  } pmbcs_link_s;

  localparam pmbcs_core_s CORE_RESET = '{
    regs: REG_RESET, nvm: REG_RESET, unit_en: 1'b1, ov_eff: ov_cap(REG_RESET),
    default: '0};
  localparam pmbcs_link_s LINK_RESET = '{ready: 1'b1, default: '0};

  pmbcs_core_s c_q;
  pmbcs_core_s c_d;
  pmbcs_link_s l_q;
  pmbcs_link_s l_d;

  logic        c_req_new;
  logic        c_clear;
  logic        c_hit;
  logic [3:0]  c_idx;
  logic [15:0] c_wr_val;
  pmbcs_regs_t c_wr_regs;
  logic        c_reject;
  logic [2:0]  c_src;
  logic [2:0]  c_retry;

  // ----------------------------------------------------------------------
  // Link domain: takes one command, waits for the core's answer
  // ----------------------------------------------------------------------
  always_comb begin
    l_d           = l_q;
    l_d.ack_s1    = c_q.ack_tgl;
    l_d.ack_s2    = l_q.ack_s1;
    l_d.rsp_valid = 1'b0;
    // Ready stays low until the answer, which also holds off commands while storing
    if (l_q.ready && lnk_req_valid_in) begin
      l_d.req     = lnk_req_in;
      l_d.req_tgl = ~l_q.req_tgl;
      l_d.ready   = 1'b0;
    end
    if (l_q.ack_s2 != l_q.ack_seen) begin
      l_d.ack_seen  = l_q.ack_s2;
      l_d.rsp_valid = 1'b1;
      l_d.rsp_data  = c_q.rsp;
      l_d.ready     = 1'b1;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      l_q <= LINK_RESET;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: decode, checks, fault actions
  // ----------------------------------------------------------------------
  // Request word is stable while the link waits, so the synced toggle qualifies it
  assign c_req_new = (c_q.req_s2 != c_q.req_seen) && !c_q.busy;
  assign c_clear   = c_req_new && (l_q.req.code == CMD_CLEAR);
  assign {c_hit, c_idx} = cmd_to_reg(l_q.req.code);
  assign c_src     = {c_q.f_s2.ot, c_q.f_s2.oc, c_q.f_s2.ov};
  assign c_retry   = {c_q.regs[R_OTA][RS_LSB +: 3] == RS_CONT,
                      c_q.regs[R_OCA][RS_LSB +: 3] == RS_CONT,
                      c_q.regs[R_OVA][RS_LSB +: 3] == RS_CONT};

  // Read-only bits of action bytes keep their value whatever is written
  always_comb begin
    if ((c_idx == R_OVA) || (c_idx == R_OCA) || (c_idx == R_OTA)) begin
      c_wr_val = {8'h00, (c_q.regs[c_idx][7:0] & ~ACT_RW_MASK)
                         | (l_q.req.data[7:0] & ACT_RW_MASK)};
    end else begin
      c_wr_val = l_q.req.data;
    end
    c_wr_regs        = c_q.regs;
    c_wr_regs[c_idx] = c_wr_val;
  end

  assign c_reject = c_req_new && l_q.req.wr && c_hit && !regs_ok(c_wr_regs);

  always_comb begin
    c_d        = c_q;
    c_d.req_s1 = l_q.req_tgl;
    c_d.req_s2 = c_q.req_s1;
    c_d.f_s1   = fault_in;
    c_d.f_s2   = c_q.f_s1;
    // Clear first, then set: an event in the clearing cycle survives
    c_d.stat.lat      = (c_clear ? '0 : c_q.stat.lat) | c_q.f_s2;
    c_d.stat.cml_cmd  = c_clear ? 1'b0 : c_q.stat.cml_cmd;
    c_d.stat.cml_data = c_clear ? 1'b0 : c_q.stat.cml_data;
    for (int i = 0; i < 3; i++) begin
      if (c_src[i]) begin
        c_d.off[i] = 1'b1;
      end else if (c_retry[i] || c_clear) begin
        c_d.off[i] = 1'b0;
      end
    end
    if (c_q.busy) begin
      if (c_q.busy_cnt == '0) begin
        c_d.busy    = 1'b0;
        c_d.ack_tgl = ~c_q.ack_tgl;
        if (c_q.op_store) begin
          c_d.nvm = c_q.regs;
        end else begin
          c_d.regs = c_q.nvm;
        end
      end else begin
        c_d.busy_cnt = c_q.busy_cnt - 1'b1;
      end
    end else if (c_req_new) begin
      c_d.req_seen = c_q.req_s2;
      c_d.ack_tgl  = ~c_q.ack_tgl;
      c_d.rsp      = '0;
      if (l_q.req.code == CMD_STORE) begin
        c_d.ack_tgl  = c_q.ack_tgl;
        c_d.busy     = 1'b1;
        c_d.op_store = 1'b1;
        c_d.busy_cnt = BUSY_W'(STORE_CYCLES - 1);
      end else if (l_q.req.code == CMD_RESTORE) begin
        c_d.ack_tgl  = c_q.ack_tgl;
        c_d.busy     = 1'b1;
        c_d.op_store = 1'b0;
        c_d.busy_cnt = BUSY_W'(RESTORE_CYCLES - 1);
      end else if (l_q.req.code == CMD_FORMAT) begin
        if (l_q.req.wr) begin
          c_d.stat.cml_data = 1'b1;
        end else begin
          c_d.rsp = {8'h00, FORMAT_VAL};
        end
      end else if (c_hit) begin
        if (!l_q.req.wr) begin
          c_d.rsp = c_q.regs[c_idx];
        end else if (c_reject) begin
          c_d.stat.cml_data = 1'b1;
        end else begin
          c_d.regs = c_wr_regs;
        end
      end else if (!c_clear) begin
        c_d.stat.cml_cmd = 1'b1;
      end
    end
    c_d.unit_en = ~|c_d.off;
    c_d.ov_eff  = ov_cap(c_q.regs);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      c_q <= CORE_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign lnk_ready_out     = l_q.ready;
  assign lnk_rsp_valid_out = l_q.rsp_valid;
  assign lnk_rsp_data_out  = l_q.rsp_data;
  assign unit_enable_out   = c_q.unit_en;
  assign ov_limit_eff_out  = c_q.ov_eff;
  assign status_out        = c_q.stat;
  assign nvm_busy_out      = c_q.busy;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_STORE_START: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_req_new && l_q.req.code == CMD_STORE)
      |=> (c_q.busy && c_q.op_store && c_q.busy_cnt == BUSY_W'(STORE_CYCLES - 1)))
    else $error("store did not start its busy wait");

  AST_RESTORE_DONE: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_q.busy && !c_q.op_store && c_q.busy_cnt == '0)
      |=> (c_q.regs == $past(c_q.nvm) && !c_q.busy))
    else $error("reload did not restore saved values");

  AST_FORMAT_READ: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_req_new && !l_q.req.wr && l_q.req.code == CMD_FORMAT)
      |=> (c_q.rsp == {8'h00, FORMAT_VAL}))
    else $error("format byte read wrong");

  AST_SET_RANGE: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    in_rng(c_q.regs[R_SET], VSET_MIN, VSET_MAX))
    else $error("setpoint out of range");

  AST_MARGIN_ORDER: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    c_q.regs[R_MHI] > c_q.regs[R_MLO])
    else $error("margin high not above low");

  AST_VIN_HYST: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    {1'b0, c_q.regs[R_VON]} >= ({1'b0, c_q.regs[R_VOFF]} + {1'b0, VIN_HYST}))
    else $error("input hysteresis below minimum");

  AST_OV_CAP: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ##1 (c_q.ov_eff <= OV_MAX && c_q.ov_eff <= $past(c_q.regs[R_OVL]) &&
         {1'b0, c_q.ov_eff} <= ({1'b0, $past(c_q.regs[R_SET])} + {1'b0, OV_HEAD})))
    else $error("effective overvoltage limit not capped");

  AST_OC_ACT_FIXED: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_q.regs[R_OCA] & ~{8'h00, ACT_RW_MASK}) == {8'h00, OCA_RST & ~ACT_RW_MASK})
    else $error("overcurrent action fixed bits changed");

  AST_NO_RETRY: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_q.off[0] && c_q.regs[R_OVA][RS_LSB +: 3] == RS_OFF && !c_clear)
      |=> (c_q.off[0] && !c_q.unit_en))
    else $error("unit restarted with retry disabled");

  AST_ZERO_DELAY: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    c_q.f_s2.ov |=> !c_q.unit_en)
    else $error("shutdown was delayed");

  AST_REJECT: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    c_reject |=> (c_q.stat.cml_data && c_q.regs == $past(c_q.regs)))
    else $error("bad write not rejected");

  AST_CLEAR: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (c_clear && c_q.f_s2 == '0) |=> (c_q.stat.lat == '0 && !c_q.stat.cml_cmd))
    else $error("clear did not clear latched flags");

  COV_STORE_DONE: cover property (
    @(posedge clk_in) disable iff (!rst_b_in)
    c_q.busy && c_q.op_store ##1 !c_q.busy);

  COV_REJECT: cover property (
    @(posedge clk_in) disable iff (!rst_b_in) c_reject);

  COV_RESTART: cover property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !c_q.unit_en ##1 c_q.unit_en);

endmodule

// [verification/pmbcs_host.sv]
// Host model: offers one command at a time on the link port and waits for its answer.
// Assumes the handler's ready/answer handshake on the link clock.
module pmbcs_host
  import pmbcs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        ready_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [15:0] rsp_data_in,
  output logic             valid_out,
  output pmbcs_req_s       req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end
  // ---------------------------
  // One command, answer bounded
  // ---------------------------
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] q, output logic ok);
    int n;
    @(negedge clk_in);
    valid_out = 1'b1;
    req_out = '{wr: w, code: c, data: d};
    while (ready_in !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    valid_out = 1'b0;
    // Released lines show garbage, not the old command
    req_out = ~req_out;
    for (n = 0; n < 400 && rsp_valid_in !== 1'b1; n++) @(negedge clk_in);
    ok = rsp_valid_in;
    q = rsp_data_in;
  endtask
endmodule

// [verification/tb.sv]
// Testbench of the command handler: limits, cross-checks, action bytes, faults, store/reload.
// Assumes the host model drives the link port; short store/reload counts are used.
module tb
  import pmbcs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, lclk = 0, rst_b = 0, valid, ready, rspv, en, busy, ok, saw_busy = 0;
  logic [15:0] rdata, ovl, rd;
  pmbcs_req_s req;
  pmbcs_fault_s fault = '0;
  pmbcs_status_s st;
  int n_tests = 0, n_mismatch = 0;
  always #10 clk = ~clk;
  initial begin
    #3;
    forever #16 lclk = ~lclk;
  end
  always @(posedge clk) if (busy === 1'b1) saw_busy <= 1'b1;
  pmbcs_top #(.STORE_CYCLES(20), .RESTORE_CYCLES(10)) i_dut (
    .clk_in(clk), .rst_b_in(rst_b), .link_clk_in(lclk), .lnk_req_valid_in(valid),
    .lnk_req_in(req), .lnk_ready_out(ready), .lnk_rsp_valid_out(rspv),
    .lnk_rsp_data_out(rdata), .fault_in(fault), .unit_enable_out(en),
    .ov_limit_eff_out(ovl), .status_out(st), .nvm_busy_out(busy));
  pmbcs_host i_host (.clk_in(lclk), .ready_in(ready), .rsp_valid_in(rspv),
    .rsp_data_in(rdata), .valid_out(valid), .req_out(req));
  // ---------------------------
  // Shared tasks
  // ---------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    i_host.cmd(w, c, d, rd, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    xfer(1'b0, c, 16'h0000);
    chk(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ---------------------------
  // Scenarios
  // ---------------------------
  task automatic t_reset;
    chk(ovl, 16'he000);
    rchk(8'h20, 16'h0014);
    rchk(8'h21, 16'hc000);
    rchk(8'h28, 16'h0000);
    rchk(8'h41, 16'h00b8);
    rchk(8'h47, 16'h00f8);
    rchk(8'h50, 16'h0080);
    $display("test reset done");
  endtask
  task automatic t_limits;
    logic [7:0] c[14] = '{8'h21, 8'h21, 8'h23, 8'h23, 8'h26, 8'h28, 8'h28, 8'h36,
                          8'h4a, 8'h51, 8'h55, 8'h55, 8'h40, 8'h40};
    logic [15:0] d[14] = '{16'h9999, 16'hd334, 16'h0401, 16'hfc00, 16'hc99a, 16'h0033,
                           16'h0032, 16'h0021, 16'h0037, 16'h007d, 16'h005b, 16'h0030,
                           16'hc000, 16'hffd8};
    logic [15:0] e[14] = '{16'hc000, 16'hc000, 16'h0000, 16'hfc00, 16'hb666, 16'h0000,
                           16'h0032, 16'h0020, 16'h0032, 16'h006e, 16'h0050, 16'h0030,
                           16'he000, 16'he000};
    for (int i = 0; i < 14; i++) begin
      xfer(1'b1, 8'h03, 16'h0000);
      xfer(1'b1, c[i], d[i]);
      chk({15'h0, st.cml_data}, {15'h0, d[i] != e[i]});
      rchk(c[i], e[i]);
    end
    xfer(1'b1, 8'h21, 16'h999a);
    chk(ovl, 16'hc99a);
    xfer(1'b1, 8'h21, 16'hd333);
    chk(ovl, 16'he000);
    $display("test limits done");
  endtask
  task automatic t_actions;
    xfer(1'b1, 8'h41, 16'hff00);
    rchk(8'h41, 16'h0080);
    xfer(1'b1, 8'h41, 16'h0010);
    rchk(8'h41, 16'h0080);
    xfer(1'b1, 8'h47, 16'h0007);
    rchk(8'h47, 16'h00c0);
    xfer(1'b1, 8'h47, 16'h0038);
    rchk(8'h47, 16'h00f8);
    xfer(1'b1, 8'h50, 16'h00ff);
    rchk(8'h50, 16'h00b8);
    $display("test actions done");
  endtask
  task automatic t_faults;
    xfer(1'b1, 8'h03, 16'h0000);
    cyc(1);
    fault.ov = 1'b1;
    cyc(5);
    chk({15'h0, en}, 16'h0000);
    fault.ov = 1'b0;
    cyc(12);
    chk({15'h0, en}, 16'h0000);
    chk({8'h0, st}, 16'h0004);
    xfer(1'b0, 8'h03, 16'h0000);
    chk({7'h0, en, st}, 16'h0100);
    cyc(1);
    fault.oc = 1'b1;
    cyc(5);
    chk({15'h0, en}, 16'h0000);
    fault.oc = 1'b0;
    cyc(12);
    chk({15'h0, en}, 16'h0001);
    fault.vin_ov = 1'b1;
    cyc(5);
    chk({7'h0, en, st}, 16'h0188);
    fault.vin_ov = 1'b0;
    fault.ot = 1'b1;
    fault.ot_warn = 1'b1;
    cyc(5);
    chk({7'h0, en, st}, 16'h00e8);
    fault.ot = 1'b0;
    fault.ot_warn = 1'b0;
    cyc(12);
    chk({15'h0, en}, 16'h0001);
    $display("test faults done");
  endtask
  task automatic t_store;
    xfer(1'b1, 8'h21, 16'hb000);
    xfer(1'b1, 8'h11, 16'h0000);
    chk({15'h0, saw_busy}, 16'h0001);
    xfer(1'b1, 8'h21, 16'ha000);
    xfer(1'b0, 8'h12, 16'h0000);
    rchk(8'h21, 16'hb000);
    xfer(1'b1, 8'h03, 16'h0000);
    xfer(1'b1, 8'h99, 16'h0000);
    xfer(1'b1, 8'h20, 16'h0055);
    chk({14'h0, st.cml_cmd, st.cml_data}, 16'h0003);
    $display("test store done");
  endtask
  initial begin
    #200us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    cyc(4);
    rst_b = 1'b1;
    t_reset();
    t_limits();
    t_actions();
    t_faults();
    t_store();
    report_and_stop();
  end
endmodule
